/* rtl/tc_status_map.svh */
// Register indices, field positions and reset values of the status block.
// Assumes inclusion by bare name from every file that decodes registers.
`ifndef TC_STATUS_MAP_SVH
`define TC_STATUS_MAP_SVH

// Register indices on the rack bus, first register is index 1
`define TC_REG_CH_FIRST 4'h1
`define TC_REG_CH_LAST 4'h8
`define TC_REG_OPEN 4'h9
`define TC_REG_RANGE 4'hA
`define TC_REG_SW_A 4'hB
`define TC_REG_SW_B 4'hC

// Field positions inside the 16-bit words
`define TC_OVER_LSB 8
`define TC_SWB_LSB 8
`define TC_SWC_BITS 2

// Reset values
`define TC_WORD_RESET 16'h0000
`define TC_FLAGS_RESET 8'h00

// Default limit readings frozen while out of range
`define TC_UNDER_LIMIT 16'h0000
`define TC_OVER_LIMIT 16'h270F

`endif

/* rtl/tc_status_pkg.sv */
// Types shared by the status block and its helpers.
// Assumes the map header supplies every numeric constant.
package tc_status_pkg;

  // One register word on the rack bus
  typedef logic [15:0] word_t;

  // Source selected for a pending read
  typedef enum logic [2:0]
  {
    SEL_NONE = 3'b000,
    SEL_CHAN = 3'b001,
    SEL_OPEN = 3'b010,
    SEL_RANGE = 3'b011,
    SEL_SW_A = 3'b100,
    SEL_SW_B = 3'b101
  } read_sel_t;

endpackage : tc_status_pkg

/* rtl/level_sync.sv */
// Two-flop synchroniser for a group of slow asynchronous levels.
// Assumes inputs change rarely, so bits of a group need no coherence.
`timescale 1ns/1ps
`default_nettype none

module level_sync #(
  parameter int WIDTH = 8
) (
  input wire logic clock,
  input wire logic srst,
  input wire logic [WIDTH-1:0] asyncIn,
  output logic [WIDTH-1:0] syncOut
);

  // Refuse an empty group
  if (WIDTH < 1)
  begin : g_bad_width
    $error("level_sync needs WIDTH of at least one");
  end

  logic [WIDTH-1:0] stage1; // Metastable stage, read only by syncOut

  //////////////////////////////////////////////////////////////////////
  // Both stages clear to zero under reset
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      stage1 <= '0;
      syncOut <= '0;
    end
    else
    begin
      stage1 <= asyncIn;
      syncOut <= stage1;
    end
  end

endmodule : level_sync

`default_nettype wire

/* rtl/reading_ram.sv */
// Small memory holding one reading word per input channel.
// Assumes one write and one read port on the same clock, read registered.
`timescale 1ns/1ps
`default_nettype none

module reading_ram #(
  parameter int DEPTH = 8,
  parameter int WIDTH = 16,
  parameter int AW = 3
) (
  input wire logic clock,
  input wire logic srst,
  input wire logic writeEnable,
  input wire logic [AW-1:0] writeAddr,
  input wire logic [WIDTH-1:0] writeData,
  input wire logic [AW-1:0] readAddr,
  output logic [WIDTH-1:0] readData
);

  // Address must reach every word
  if (DEPTH < 1 || (1 << AW) < DEPTH)
  begin : g_bad_depth
    $error("reading_ram address too narrow for DEPTH");
  end

  logic [WIDTH-1:0] mem [DEPTH]; // Storage, no reset to keep it a plain RAM

  //////////////////////////////////////////////////////////////////////
  // Write port
  always_ff @(posedge clock)
  begin
    if (writeEnable)
    begin
      mem[writeAddr] <= writeData;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Registered read, old data on a same-cycle write
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      readData <= '0;
    end
    else
    begin
      readData <= mem[readAddr];
    end
  end

endmodule : reading_ram

`default_nettype wire

/* rtl/thermocouple_status_flags.sv */
// Status registers of an eight-channel thermocouple input module.
// Assumes the converter delivers results on this clock, switches are async.
//
// Overview of operation
// - Open input sets channel's open bit
// - Open bit clear during normal operation
// - Open register upper byte has no function
// - Below range sets channel's under bit
// - Under range freezes reading at under limit
// - Open input also sets under bit
// - In range clears under bit, resumes updates
// - Above range sets bit eight plus channel unless input open
// - Over range freezes reading at over limit unless under or open
// - In range clears over bit, resumes updates
// - Switch registers ignore bus writes
// - Switch bit one when ON, zero OFF
// - First switch low byte is bank A
// - First switch high byte is bank B
// - Second switch bits one, two: bank C
// - Second switch bits three up unused
// - Registers one to eight hold channel readings
`timescale 1ns/1ps
`default_nettype none
`include "tc_status_map.svh"

module thermocouple_status_flags
  import tc_status_pkg::*;
#(
  parameter int CHANNELS = 8,
  parameter logic [15:0] UNDER_LIMIT = `TC_UNDER_LIMIT,
  parameter logic [15:0] OVER_LIMIT = `TC_OVER_LIMIT
) (
  input wire logic clock,
  input wire logic srst,
  input wire logic sampleValid,
  input wire logic [2:0] sampleChannel,
  input wire logic [15:0] sampleValue,
  input wire logic openDetect,
  input wire logic underRange,
  input wire logic overRange,
  input wire logic [7:0] config_switch_bank_a,
  input wire logic [7:0] config_switch_bank_b,
  input wire logic [1:0] config_switch_bank_c,
  input wire logic readStrobe,
  input wire logic writeStrobe,
  input wire logic [3:0] regIndex,
  input wire logic [15:0] writeData,
  output logic [15:0] readData,
  output logic readValid,
  output logic [7:0] openFlags,
  output logic [7:0] underFlags,
  output logic [7:0] overFlags
);

  // Flag bytes and channel index are sized for exactly eight channels
  if (CHANNELS != 8)
  begin : g_bad_channels
    $error("thermocouple_status_flags serves exactly eight channels");
  end

  //////////////////////////////////////////////////////////////////////
  // Declarations

  logic [7:0] bankA; // Synchronised switch bank A
  logic [7:0] bankB; // Synchronised switch bank B
  logic [1:0] bankC; // Synchronised switch bank C
  logic ramWe; // Registered write of a reading
  logic [2:0] ramWa; // Channel written
  word_t ramWd; // Reading written, already limited
  logic [2:0] ramRa; // Channel read address
  word_t ramRd; // Reading out of the memory
  read_sel_t pendSel; // Source of the read in flight
  logic pendValid; // Read in flight, one cycle after strobe
  read_sel_t next_sel; // Decoded source of a new read
  word_t next_data; // Word chosen for the read in flight
  logic writeSeen; // Write strobes are accepted and dropped
  word_t writeDrop; // Data of a dropped write

  // Map a register index to its source; unmapped indices give none
  function automatic read_sel_t decodeIndex(input logic [3:0] idx);
    if (idx >= `TC_REG_CH_FIRST && idx <= `TC_REG_CH_LAST)
    begin
      return SEL_CHAN;
    end
    case (idx)
      `TC_REG_OPEN: return SEL_OPEN;
      `TC_REG_RANGE: return SEL_RANGE;
      `TC_REG_SW_A: return SEL_SW_A;
      `TC_REG_SW_B: return SEL_SW_B;
      default: return SEL_NONE;
    endcase
  endfunction : decodeIndex

  //////////////////////////////////////////////////////////////////////
  // Switch pins come from outside, two flops before any use

  level_sync #(.WIDTH(8)) u_sync_a (
    .clock(clock),
    .srst(srst),
    .asyncIn(config_switch_bank_a),
    .syncOut(bankA)
  );

  level_sync #(.WIDTH(8)) u_sync_b (
    .clock(clock),
    .srst(srst),
    .asyncIn(config_switch_bank_b),
    .syncOut(bankB)
  );

  level_sync #(.WIDTH(2)) u_sync_c (
    .clock(clock),
    .srst(srst),
    .asyncIn(config_switch_bank_c),
    .syncOut(bankC)
  );

  //////////////////////////////////////////////////////////////////////
  // Per-channel flags, recomputed from every converter result.
  // Flags are levels owned by hardware; software cannot clear them.
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      openFlags <= `TC_FLAGS_RESET;
      underFlags <= `TC_FLAGS_RESET;
      overFlags <= `TC_FLAGS_RESET;
    end
    else if (sampleValid)
    begin
      openFlags[sampleChannel] <= openDetect;
      underFlags[sampleChannel] <= underRange | openDetect;
      // An open input reads as under range, never as over range
      overFlags[sampleChannel] <= overRange & ~openDetect;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Reading write, frozen at a limit while out of range
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      ramWe <= 1'b0;
      ramWa <= 3'h0;
      ramWd <= `TC_WORD_RESET;
    end
    else
    begin
      ramWe <= sampleValid;
      ramWa <= sampleChannel;
      if (underRange || openDetect)
      begin
        ramWd <= UNDER_LIMIT;
      end
      else if (overRange)
      begin
        ramWd <= OVER_LIMIT;
      end
      else
      begin
        ramWd <= sampleValue;
      end
    end
  end

  // Register index 1 maps to channel 0
  assign ramRa = 3'(regIndex - `TC_REG_CH_FIRST);

  reading_ram #(.DEPTH(8), .WIDTH(16), .AW(3)) u_readings (
    .clock(clock),
    .srst(srst),
    .writeEnable(ramWe),
    .writeAddr(ramWa),
    .writeData(ramWd),
    .readAddr(ramRa),
    .readData(ramRd)
  );

  //////////////////////////////////////////////////////////////////////
  // Read pipeline stage one: decode, memory reads alongside
  always_comb
  begin
    next_sel = decodeIndex(regIndex);
  end

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      pendValid <= 1'b0;
      pendSel <= SEL_NONE;
    end
    else
    begin
      pendValid <= readStrobe;
      pendSel <= readStrobe ? next_sel : SEL_NONE;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Read pipeline stage two: choose the word
  always_comb
  begin
    next_data = `TC_WORD_RESET; // Unused bits and unmapped reads give zero
    case (pendSel)
      SEL_CHAN: next_data = ramRd;
      SEL_OPEN: next_data[7:0] = openFlags; // Upper byte stays zero
      SEL_RANGE:
      begin
        next_data[7:0] = underFlags;
        next_data[`TC_OVER_LSB +: 8] = overFlags;
      end
      SEL_SW_A:
      begin
        next_data[7:0] = bankA;
        next_data[`TC_SWB_LSB +: 8] = bankB;
      end
      // Bits above bank C stay zero
      SEL_SW_B: next_data[`TC_SWC_BITS-1:0] = bankC;
      default: next_data = `TC_WORD_RESET;
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      readValid <= 1'b0;
      readData <= `TC_WORD_RESET;
    end
    else
    begin
      readValid <= pendValid;
      readData <= pendValid ? next_data : `TC_WORD_RESET;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Bus writes: every register is read-only, so a write is swallowed.
  // Kept in a flop only so the data lines have a load.
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      writeSeen <= 1'b0;
      writeDrop <= `TC_WORD_RESET;
    end
    else
    begin
      writeSeen <= writeStrobe; // No effect on any register
      writeDrop <= writeData;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);

  sequence readOf(logic [3:0] idx);
    readStrobe && regIndex == idx;
  endsequence

  sequence answerIn2;
    ##1 pendValid ##1 readValid;
  endsequence

  chk_open_set: assert property (sampleValid && openDetect |=>
    openFlags[$past(sampleChannel)] && underFlags[$past(sampleChannel)])
    else $error("open input did not set open and under bits");

  chk_open_clear: assert property (sampleValid && !openDetect |=>
    !openFlags[$past(sampleChannel)])
    else $error("open bit set without open input");

  chk_open_upper: assert property (readOf(`TC_REG_OPEN) |-> answerIn2
    ##0 (readData[15:8] == 8'h00 && readData[7:0] == $past(openFlags)))
    else $error("open register read wrong");

  chk_under_set: assert property (sampleValid && underRange |=>
    underFlags[$past(sampleChannel)] && ramWd == UNDER_LIMIT)
    else $error("under range bit not set");

  chk_freeze_under: assert property (sampleValid && (underRange || openDetect) |=>
    ramWe && ramWd == UNDER_LIMIT && ramWa == $past(sampleChannel))
    else $error("reading not frozen at under limit");

  chk_in_range: assert property (sampleValid && !underRange && !overRange &&
    !openDetect |=> ramWd == $past(sampleValue) &&
    !underFlags[$past(sampleChannel)] && !overFlags[$past(sampleChannel)])
    else $error("in-range sample not taken or flag left set");

  chk_over_set: assert property (sampleValid && overRange && !underRange &&
    !openDetect |=> overFlags[$past(sampleChannel)] && ramWd == OVER_LIMIT)
    else $error("over range not flagged or not frozen");

  chk_range_read: assert property (readOf(`TC_REG_RANGE) |-> answerIn2
    ##0 readData == {$past(overFlags), $past(underFlags)})
    else $error("range register read wrong");

  chk_switch_a: assert property (readOf(`TC_REG_SW_A) |-> answerIn2
    ##0 readData == {$past(bankB), $past(bankA)})
    else $error("switch bank A/B read wrong");

  chk_switch_b: assert property (readOf(`TC_REG_SW_B) |-> answerIn2
    ##0 readData == {14'h0000, $past(bankC)})
    else $error("switch bank C read wrong");

  chk_unmapped_zero: assert property (readStrobe && decodeIndex(regIndex) == SEL_NONE
    |-> answerIn2 ##0 readData == 16'h0000)
    else $error("unmapped read not zero");

endmodule : thermocouple_status_flags

`default_nettype wire

/* verif/rack_master_model.sv */
// Rack bus master model: reads and writes status registers.
// Assumes one request at a time and the answer two edges later.
`timescale 1ns/1ps
`default_nettype none

module rack_master_model
  import tc_status_pkg::*;
(
  input wire logic clock,
  input wire logic [15:0] readData,
  input wire logic readValid,
  output logic readStrobe,
  output logic writeStrobe,
  output logic [3:0] regIndex,
  output logic [15:0] writeData
);
  // Idle bus from time zero
  initial
  begin
    readStrobe = 1'b0;
    writeStrobe = 1'b0;
    regIndex = 4'h0;
    writeData = 16'h0000;
  end

  ////////////////////////////////////////
  // One read: strobe one cycle, answer after two more edges
  task automatic doRead(input logic [3:0] idx, output word_t data, output logic valid);
    @(posedge clock);
    #2;
    readStrobe = 1'b1;
    regIndex = idx;
    @(posedge clock);
    #2;
    readStrobe = 1'b0;
    // Released index changes, so a stale latch shows up
    regIndex = ~idx;
    @(posedge clock);
    // Answer launched at this edge, taken at the next one while it stands
    @(posedge clock);
    data = readData;
    valid = readValid;
  endtask : doRead

  // One write: strobe one cycle, data inverted after release
  task automatic doWrite(input logic [3:0] idx, input word_t data);
    @(posedge clock);
    #2;
    writeStrobe = 1'b1;
    regIndex = idx;
    writeData = data;
    @(posedge clock);
    #2;
    writeStrobe = 1'b0;
    writeData = ~data;
  endtask : doWrite
endmodule : rack_master_model
`default_nettype wire

/* verif/thermocouple_status_flags_tb.sv */
// Testbench of the thermocouple status registers.
// Assumes the rack master model and defaults of both limit parameters.
`timescale 1ns/1ps
`default_nettype none
`include "tc_status_map.svh"

module thermocouple_status_flags_tb
  import tc_status_pkg::*;
;
  // One converter result beside the reading it should leave
  typedef struct {logic [2:0] ch; word_t val; logic op, un, ov; word_t rd;} row_t;
  localparam word_t UL = `TC_UNDER_LIMIT;
  localparam word_t OL = `TC_OVER_LIMIT;
  row_t rows [10] = '{
    '{3'h0, 16'h04D2, 1'b0, 1'b0, 1'b0, 16'h04D2},
    '{3'h1, 16'h1111, 1'b0, 1'b1, 1'b0, UL},
    '{3'h1, 16'h9999, 1'b0, 1'b1, 1'b0, UL},
    '{3'h2, 16'h2222, 1'b0, 1'b0, 1'b1, OL},
    '{3'h3, 16'h3333, 1'b1, 1'b0, 1'b0, UL},
    '{3'h7, 16'h7777, 1'b0, 1'b0, 1'b1, OL},
    '{3'h7, 16'h0777, 1'b0, 1'b0, 1'b0, 16'h0777},
    '{3'h1, 16'h0111, 1'b0, 1'b0, 1'b0, 16'h0111},
    '{3'h4, 16'h4444, 1'b1, 1'b0, 1'b1, UL},
    '{3'h5, 16'h5555, 1'b0, 1'b1, 1'b1, UL}};
  logic clock, srst, sampleValid, openDetect, underRange, overRange;
  logic readStrobe, writeStrobe, readValid;
  logic [2:0] sampleChannel;
  logic [3:0] regIndex;
  logic [7:0] swA, swB, openFlags, underFlags, overFlags;
  logic [7:0] eo = 8'h00, eu = 8'h00, ev = 8'h00; // Expected flags
  logic [1:0] swC;
  word_t sampleValue, writeData, readData;
  int err_count = 0;
  int num_checks = 0;

  thermocouple_status_flags thermocouple_status_flags_inst (.clock(clock), .srst(srst),
    .sampleValid(sampleValid), .sampleChannel(sampleChannel), .sampleValue(sampleValue),
    .openDetect(openDetect), .underRange(underRange), .overRange(overRange),
    .config_switch_bank_a(swA), .config_switch_bank_b(swB), .config_switch_bank_c(swC),
    .readStrobe(readStrobe), .writeStrobe(writeStrobe), .regIndex(regIndex),
    .writeData(writeData), .readData(readData), .readValid(readValid),
    .openFlags(openFlags), .underFlags(underFlags), .overFlags(overFlags));
  rack_master_model rack_master_model_inst (.clock(clock), .readData(readData),
    .readValid(readValid), .readStrobe(readStrobe), .writeStrobe(writeStrobe),
    .regIndex(regIndex), .writeData(writeData));

  ////////////////////////////////////////
  // 40 MHz clock
  initial
  begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  // Verdict and end of run
  task automatic end_sim();
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : end_sim

  // Compare one word
  task automatic checkWord(input string name, input word_t expV, input word_t gotV);
    num_checks = num_checks + 1;
    if (gotV !== expV)
    begin
      err_count = err_count + 1;
      $display("wrong value %s expected %h seen %h", name, expV, gotV);
    end
  endtask : checkWord

  // Read through the master, check data and answer flag
  task automatic readCheck(input string name, input logic [3:0] idx, input word_t expV);
    word_t d;
    logic v;
    rack_master_model_inst.doRead(idx, d, v);
    checkWord(name, expV, d);
    checkWord("readValid", 16'h0001, {15'h0000, v});
  endtask : readCheck

  // One converter result, qualifiers dropped after the pulse
  task automatic sendSample(input row_t r);
    @(posedge clock);
    #2;
    sampleValid = 1'b1;
    sampleChannel = r.ch;
    sampleValue = r.val;
    {openDetect, underRange, overRange} = {r.op, r.un, r.ov};
    @(posedge clock);
    #2;
    sampleValid = 1'b0;
    sampleValue = ~r.val;
    {openDetect, underRange, overRange} = 3'b000;
  endtask : sendSample

  // Hang guard, far beyond the roughly 120 cycles needed
  initial
  begin
    #20000;
    err_count = err_count + 1;
    end_sim();
  end

  ////////////////////////////////////////
  // Main sequence
  initial
  begin
    {srst, sampleValid, openDetect, underRange, overRange} = 5'b10000;
    sampleChannel = 3'h0;
    sampleValue = 16'h0000;
    {swA, swB, swC} = {8'hA5, 8'h3C, 2'b10};
    repeat (6) @(posedge clock);
    #2;
    srst = 1'b0;
    foreach (rows[i])
    begin
      sendSample(rows[i]);
      // Flag model: open forces under, suppresses over
      eo[rows[i].ch] = rows[i].op;
      eu[rows[i].ch] = rows[i].un | rows[i].op;
      ev[rows[i].ch] = rows[i].ov & ~rows[i].op;
      readCheck("reading", {1'b0, rows[i].ch} + 4'h1, rows[i].rd);
      checkWord("openFlags", {8'h00, eo}, {8'h00, openFlags});
      checkWord("underFlags", {8'h00, eu}, {8'h00, underFlags});
      checkWord("overFlags", {8'h00, ev}, {8'h00, overFlags});
    end
    readCheck("openReg", 4'h9, {8'h00, eo});
    readCheck("rangeReg", 4'hA, {ev, eu});
    readCheck("switchA", 4'hB, 16'h3CA5);
    readCheck("switchB", 4'hC, 16'h0002);
    // Every switch flipped, so both levels are seen on each bit
    #2;
    {swA, swB, swC} = {8'h5A, 8'hC3, 2'b01};
    repeat (3) @(posedge clock);
    rack_master_model_inst.doWrite(4'hB, 16'h0000);
    rack_master_model_inst.doWrite(4'hC, 16'hFFFF);
    rack_master_model_inst.doWrite(4'hA, 16'hFFFF);
    readCheck("switchA", 4'hB, 16'hC35A);
    readCheck("switchB", 4'hC, 16'h0001);
    readCheck("rangeReg", 4'hA, {ev, eu});
    readCheck("unmapped", 4'hD, 16'h0000);
    // Reset in mid-run clears every flag
    @(posedge clock);
    #2;
    srst = 1'b1;
    repeat (6) @(posedge clock);
    #2;
    srst = 1'b0;
    checkWord("underFlags", 16'h0000, {8'h00, underFlags});
    readCheck("rangeReg", 4'hA, 16'h0000);
    readCheck("switchA", 4'hB, 16'hC35A);
    end_sim();
  end
endmodule : thermocouple_status_flags_tb
`default_nettype wire
